//--- common/sps_pkg.sv
// package of register map, field positions and carrier types for the serial port status block
package sps_pkg;

	// register index on the plain register port
	localparam logic [2:0] SPS_ADDR_STATUS = 3'h0;
	localparam logic [2:0] SPS_ADDR_RXBUF  = 3'h1;
	localparam logic [2:0] SPS_ADDR_TXBUF  = 3'h2;
	localparam logic [2:0] SPS_ADDR_IE     = 3'h3;
	localparam logic [2:0] SPS_ADDR_IFG    = 3'h4;
	localparam logic [2:0] SPS_ADDR_CTRL   = 3'h5;
	localparam logic [2:0] SPS_ADDR_IFGCLR = 3'h6;

	// serial_status fields
	localparam int SPS_ST_LOOPBACK = 7;
	localparam int SPS_ST_FE       = 6;
	localparam int SPS_ST_OE       = 5;
	localparam int SPS_ST_BUSY     = 0;

	// control register fields
	localparam int SPS_CTRL_SEVEN  = 0;

	// shared interrupt enable and flag fields
	localparam int SPS_IRQ_B_TX    = 3;
	localparam int SPS_IRQ_B_RX    = 2;
	localparam int SPS_IRQ_A_TX    = 1;
	localparam int SPS_IRQ_A_RX    = 0;

	// reset values
	localparam logic [3:0] SPS_IE_RESET  = 4'h0;
	localparam logic [3:0] SPS_IFG_RESET = 4'hA;
	localparam logic [7:0] SPS_BYTE_ZERO = 8'h00;

	// character lengths in bits, less one, as the bit counter sees them
	localparam logic [2:0] SPS_LAST_BIT_8 = 3'h7;
	localparam logic [2:0] SPS_LAST_BIT_7 = 3'h6;

	// synchroniser lanes
	localparam int SPS_SYNC_W    = 2;
	localparam int SPS_LANE_SCLK = 1;
	localparam int SPS_LANE_DIN  = 0;

	// register port request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sps_bus_req_t;

	// serial pins as seen by the block
	typedef struct packed {
		logic sclk;
		logic mosi;
	} sps_pins_in_t;

	// events and levels from the second serial unit
	typedef struct packed {
		logic rx_done;
		logic tx_empty;
	} sps_unit_b_t;

endpackage

//--- hw/sps_sync.sv
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
module sps_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         srst,
	// asynchronous in, synchronised out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} sps_sync_st_t;

	sps_sync_st_t st;
	sps_sync_st_t next_st;

	// first stage feeds only the second stage
	always_comb begin
		next_st.first  = d;
		next_st.second = st.first;
	end

	// registered state
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.second;

endmodule
`default_nettype wire

//--- hw/sps_serial_port.sv
// serial port unit: status, receive and transmit buffers, shared interrupt enable and flags
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module sps_serial_port
	import sps_pkg::*;
(
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         srst,
	// register port
	input  wire sps_bus_req_t bus_req,
	output logic        [7:0] rdata,
	// serial link, this unit is a clock follower in mode 0
	input  wire sps_pins_in_t pins,
	output logic              miso,
	// second serial unit, same clock
	input  wire sps_unit_b_t  unit_b,
	// interrupt request
	output logic              irq
);

	typedef struct packed {
		logic       loopback_enable;
		logic       framing_error_flag;
		logic       overrun_error_flag;
		logic       seven_bit_char_select;
		logic [7:0] receive_buffer;
		logic [7:0] transmit_buffer;
		logic       tx_full;
		logic [3:0] shared_interrupt_enable;
		logic [3:0] shared_interrupt_flags;
		logic [7:0] rx_shift;
		logic [7:0] tx_shift;
		logic       tx_loaded;
		logic [2:0] bit_cnt;
		logic       sclk_prev;
		logic [7:0] rdata;
		logic       miso;
		logic       irq;
	} sps_state_t;

	sps_state_t st;
	sps_state_t next_st;

	logic [SPS_SYNC_W-1:0] pins_sync;
	logic                  sclk_s;
	logic                  din_s;

	// link pins come from another clock domain
	sps_sync #(
		.W (SPS_SYNC_W)
	) u_sync (
		.sys_clk (sys_clk),
		.srst    (srst),
		.d       ({pins.sclk, pins.mosi}),
		.q       (pins_sync)
	);

	assign sclk_s = pins_sync[SPS_LANE_SCLK];
	assign din_s  = pins_sync[SPS_LANE_DIN];

	// helper terms
	logic       sclk_rise;
	logic       sclk_fall;
	logic [2:0] last_bit;
	logic       tx_bit;
	logic       rx_bit;
	logic       char_done;
	logic [7:0] rx_char;
	logic       busy_flag;
	logic [7:0] serial_status;
	logic       rd_rxbuf;
	logic       wr_txbuf;

	// edge finding on the synchronised link clock
	always_comb begin
		sclk_rise = sclk_s & ~st.sclk_prev;
		sclk_fall = ~sclk_s & st.sclk_prev;
	end

	// character framing and data path terms
	always_comb begin
		last_bit  = st.seven_bit_char_select ? SPS_LAST_BIT_7 : SPS_LAST_BIT_8;
		// seven-bit characters leave the shifter from bit 6, so no realignment is needed
		tx_bit    = st.seven_bit_char_select ? st.tx_shift[6] : st.tx_shift[7];
		rx_bit    = st.loopback_enable ? tx_bit : din_s;
		char_done = sclk_rise && (st.bit_cnt == last_bit);
		rx_char   = {st.rx_shift[6:0], rx_bit};
		if (st.seven_bit_char_select) begin
			rx_char[7] = 1'b0;
		end
		busy_flag = (st.bit_cnt != 3'h0) || st.tx_loaded;
		rd_rxbuf  = bus_req.rd && (bus_req.addr == SPS_ADDR_RXBUF);
		wr_txbuf  = bus_req.wr && (bus_req.addr == SPS_ADDR_TXBUF);
	end

	// status as software sees it; unused bits read zero
	always_comb begin
		serial_status                  = SPS_BYTE_ZERO;
		serial_status[SPS_ST_LOOPBACK] = st.loopback_enable;
		serial_status[SPS_ST_FE]       = st.framing_error_flag;
		serial_status[SPS_ST_OE]       = st.overrun_error_flag;
		serial_status[SPS_ST_BUSY]     = busy_flag;
	end

	// next state: register writes first, then hardware events so a set wins over a clear
	always_comb begin
		next_st           = st;
		next_st.sclk_prev = sclk_s;
		next_st.rdata     = SPS_BYTE_ZERO;

		// register writes
		if (bus_req.wr) begin
			case (bus_req.addr)
				SPS_ADDR_STATUS: begin
					next_st.loopback_enable    = bus_req.wdata[SPS_ST_LOOPBACK];
					next_st.framing_error_flag = bus_req.wdata[SPS_ST_FE];
					// software must leave this bit alone; a write still lands as stored
					next_st.overrun_error_flag = bus_req.wdata[SPS_ST_OE];
				end
				SPS_ADDR_TXBUF: begin
					next_st.transmit_buffer = bus_req.wdata;
					if (st.seven_bit_char_select) begin
						next_st.transmit_buffer[7] = 1'b0;
					end
					next_st.tx_full                              = 1'b1;
					next_st.shared_interrupt_flags[SPS_IRQ_A_TX] = 1'b0;
				end
				SPS_ADDR_IE: begin
					next_st.shared_interrupt_enable = bus_req.wdata[3:0];
				end
				SPS_ADDR_IFG: begin
					next_st.shared_interrupt_flags = bus_req.wdata[3:0];
				end
				SPS_ADDR_IFGCLR: begin
					next_st.shared_interrupt_flags = st.shared_interrupt_flags & ~bus_req.wdata[3:0];
				end
				SPS_ADDR_CTRL: begin
					next_st.seven_bit_char_select = bus_req.wdata[SPS_CTRL_SEVEN];
				end
				default: begin
					next_st.loopback_enable = st.loopback_enable;
				end
			endcase
		end

		// register reads: data stands in the next cycle only
		if (bus_req.rd) begin
			case (bus_req.addr)
				SPS_ADDR_STATUS: next_st.rdata = serial_status;
				SPS_ADDR_RXBUF:  next_st.rdata = st.receive_buffer;
				SPS_ADDR_TXBUF:  next_st.rdata = st.transmit_buffer;
				SPS_ADDR_IE:     next_st.rdata = {4'h0, st.shared_interrupt_enable};
				SPS_ADDR_IFG:    next_st.rdata = {4'h0, st.shared_interrupt_flags};
				SPS_ADDR_CTRL:   next_st.rdata = {7'h00, st.seven_bit_char_select};
				default:         next_st.rdata = SPS_BYTE_ZERO;
			endcase
		end

		// reading the receive buffer clears its error flags and its interrupt flag
		if (rd_rxbuf) begin
			next_st.overrun_error_flag                   = 1'b0;
			next_st.framing_error_flag                   = 1'b0;
			next_st.shared_interrupt_flags[SPS_IRQ_A_RX] = 1'b0;
		end

		// receive shifter samples on the rising link clock edge
		if (sclk_rise) begin
			next_st.rx_shift = rx_char;
			next_st.bit_cnt  = st.bit_cnt + 3'h1;
		end

		// a whole character moves into the receive buffer
		if (char_done) begin
			next_st.bit_cnt        = 3'h0;
			next_st.receive_buffer = rx_char;
			next_st.tx_loaded      = 1'b0;
			// an unread character is lost; a read in this very cycle counts as read
			if (st.shared_interrupt_flags[SPS_IRQ_A_RX] && !rd_rxbuf) begin
				next_st.overrun_error_flag = 1'b1;
			end
			next_st.shared_interrupt_flags[SPS_IRQ_A_RX] = 1'b1;
		end

		// transmit shifter changes data on the falling edge inside a character
		if (sclk_fall && (st.bit_cnt != 3'h0)) begin
			next_st.tx_shift = {st.tx_shift[6:0], 1'b0};
		end

		// between characters the buffer moves into the shifter; idle sends what is left in the shifter, the last character's low bit then zeros
		if ((st.bit_cnt == 3'h0) && !st.tx_loaded && !sclk_rise && st.tx_full && !wr_txbuf) begin
			next_st.tx_shift  = st.transmit_buffer;
			next_st.tx_loaded = 1'b1;
			next_st.tx_full   = 1'b0;
		end

		// transmit flag follows an empty buffer; second unit feeds its own flags
		if (!next_st.tx_full) begin
			next_st.shared_interrupt_flags[SPS_IRQ_A_TX] = 1'b1;
		end
		if (unit_b.tx_empty) begin
			next_st.shared_interrupt_flags[SPS_IRQ_B_TX] = 1'b1;
		end
		if (unit_b.rx_done) begin
			next_st.shared_interrupt_flags[SPS_IRQ_B_RX] = 1'b1;
		end

		// serial output and interrupt come straight from flops
		next_st.miso = st.loopback_enable ? 1'b0 : tx_bit;
		next_st.irq  = |(next_st.shared_interrupt_flags & next_st.shared_interrupt_enable);
	end

	// registered state
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st                         <= '0;
			st.loopback_enable         <= 1'b0;
			st.shared_interrupt_enable <= SPS_IE_RESET;
			st.shared_interrupt_flags  <= SPS_IFG_RESET;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign rdata = st.rdata;
	assign miso  = st.miso;
	assign irq   = st.irq;

endmodule
`default_nettype wire

//--- tb/sps_serial_port_assertions.sv
// port-level checker for the serial port block
`timescale 1ns/100ps
`default_nettype none
module sps_serial_port_checker
	import sps_pkg::*;
(
	// clock and reset
	input wire logic         sys_clk,
	input wire logic         srst,
	// watched ports
	input wire sps_bus_req_t bus_req,
	input wire logic   [7:0] rdata,
	input wire sps_pins_in_t pins,
	input wire logic         miso,
	input wire sps_unit_b_t  unit_b,
	input wire logic         irq
);
	logic [3:0] ie_copy;
	logic       lb_copy;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// enable and loopback copies rebuilt from bus writes, hardware never alters them
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ie_copy <= 4'h0;
			lb_copy <= 1'b0;
		end else if (bus_req.wr && bus_req.addr == SPS_ADDR_IE) begin
			ie_copy <= bus_req.wdata[3:0];
		end else if (bus_req.wr && bus_req.addr == SPS_ADDR_STATUS) begin
			lb_copy <= bus_req.wdata[SPS_ST_LOOPBACK];
		end
	end
	a_rdata_quiet: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
		else $error("read data outside its cycle");
	a_ie_readback: assert property (bus_req.wr && bus_req.addr == SPS_ADDR_IE ##1
		bus_req.rd && bus_req.addr == SPS_ADDR_IE |=> rdata == {4'h0, $past(bus_req.wdata[3:0], 2)})
		else $error("enable readback differs");
	a_txb_flag: assert property (unit_b.tx_empty && $past(unit_b.tx_empty) && bus_req.rd
		&& bus_req.addr == SPS_ADDR_IFG |=> rdata[SPS_IRQ_B_TX])
		else $error("second unit transmit flag low while empty");
	a_irq_off: assert property ((ie_copy == 4'h0) [*3] |-> !irq)
		else $error("interrupt with all enables clear");
	a_miso_loop: assert property (lb_copy [*3] |-> !miso)
		else $error("serial output driven during loopback");
	a_miso_quiet: assert property (pins.sclk [*3] |-> $stable(miso))
		else $error("serial output moved while clock high");
	a_rx_clr: assert property (bus_req.rd && bus_req.addr == SPS_ADDR_RXBUF ##2
		bus_req.rd && bus_req.addr == SPS_ADDR_IFG |=> !rdata[SPS_IRQ_A_RX])
		else $error("receive flag survived buffer read");
	a_ovr_clr: assert property (bus_req.rd && bus_req.addr == SPS_ADDR_RXBUF ##2
		bus_req.rd && bus_req.addr == SPS_ADDR_STATUS |=> !rdata[SPS_ST_OE])
		else $error("overrun survived buffer read");
	a_txbuf_clr: assert property (bus_req.wr && bus_req.addr == SPS_ADDR_TXBUF ##1
		bus_req.rd && bus_req.addr == SPS_ADDR_IFG |=> !rdata[SPS_IRQ_A_TX])
		else $error("transmit flag survived buffer write");
endmodule
bind sps_serial_port sps_serial_port_checker sps_serial_port_checker_inst (.sys_clk, .srst,
	.bus_req, .rdata, .pins, .miso, .unit_b, .irq);
`default_nettype wire

//--- tb/sps_link_master.sv
// behavioural link master clocking characters through the serial unit
`timescale 1ns/100ps
`default_nettype none
module sps_link_master (
	// link pins
	output var logic sclk,
	output var logic mosi,
	input  wire logic miso
);
	// clock stands low between frames
	initial begin
		sclk = 1'b0;
		mosi = 1'b0;
	end
	// miso is taken just before the fall, far from its own update after the previous fall
	task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q);
		q = 8'h00;
		#13;
		for (int i = n - 1; i >= 0; i--) begin
			mosi = d[i];
			#200 sclk = 1'b1;
			#199 q = {q[6:0], miso};
			#1 sclk = 1'b0;
		end
		#200 mosi = ~mosi; // released line shows no stale level
	endtask
endmodule
`default_nettype wire

//--- tb/sps_serial_port_bench.sv
// bench for the serial port block: register traffic and link frames
`timescale 1ns/100ps
`default_nettype none
module sps_serial_port_bench
	import sps_pkg::*;
;
	logic         sys_clk = 1'b0;
	logic         srst;
	sps_bus_req_t req;
	sps_unit_b_t  ub;
	sps_pins_in_t pins;
	logic   [7:0] rdata;
	logic   [7:0] got;
	logic         miso;
	logic         irq;
	wire          sclk;
	wire          mosi;
	int           num_errors;
	int           n_tests;
	assign pins = {sclk, mosi};
	sps_serial_port sps_serial_port_inst (.sys_clk(sys_clk), .srst(srst), .bus_req(req),
		.rdata(rdata), .pins(pins), .miso(miso), .unit_b(ub), .irq(irq));
	sps_link_master sps_link_master_inst (.sclk(sclk), .mosi(mosi), .miso(miso));
	always #25 sys_clk = ~sys_clk;
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
			num_errors++;
		end
	endtask
	// a write leaves its strobe up so a read can follow with no gap
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		req <= '{a, d, 1'b1, 1'b0};
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge sys_clk);
		req <= '0;
		#1;
		chk(rdata, e);
	endtask
	task automatic irq_is(input logic e);
		repeat (2) @(posedge sys_clk);
		#1;
		chk({7'h00, irq}, {7'h00, e});
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// watchdog, about ten times the expected run
	initial begin
		#200000;
		num_errors++;
		report_and_stop();
	end
	initial begin
		srst = 1'b1;
		req = '0;
		ub = '0;
		num_errors = 0;
		n_tests = 0;
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		rd(SPS_ADDR_STATUS, 8'h00);
		rd(SPS_ADDR_IE, 8'h00);
		rd(SPS_ADDR_IFG, 8'h0A);
		rd(3'h7, 8'h00);
		wr(SPS_ADDR_IE, 8'hFF);
		rd(SPS_ADDR_IE, 8'h0F);
		// plain store of the flags; the empty transmit buffer puts bit 1 straight back
		wr(SPS_ADDR_IFG, 8'h05);
		rd(SPS_ADDR_IFG, 8'h07);
		wr(SPS_ADDR_IFGCLR, 8'h0D);
		rd(SPS_ADDR_IFG, 8'h02);
		@(posedge sys_clk) ub.rx_done <= 1'b1;
		@(posedge sys_clk) ub.rx_done <= 1'b0;
		rd(SPS_ADDR_IFG, 8'h06);
		wr(SPS_ADDR_IE, 8'h04);
		rd(SPS_ADDR_IE, 8'h04);
		irq_is(1'b1);
		wr(SPS_ADDR_IFGCLR, 8'h04);
		rd(SPS_ADDR_IFG, 8'h02);
		irq_is(1'b0);
		@(posedge sys_clk) ub.tx_empty <= 1'b1;
		rd(SPS_ADDR_IFG, 8'h0A);
		// plain frame with busy sampled mid-character
		wr(SPS_ADDR_TXBUF, 8'hA5);
		rd(SPS_ADDR_IFG, 8'h08);
		fork
			sps_link_master_inst.xfer(8'h3C, 8, got);
			begin
				repeat (30) @(posedge sys_clk);
				rd(SPS_ADDR_STATUS, 8'h01);
			end
		join
		chk(got, 8'hA5);
		rd(SPS_ADDR_IFG, 8'h0B);
		rd(SPS_ADDR_RXBUF, 8'h3C);
		rd(SPS_ADDR_IFG, 8'h0A);
		// two characters with no read between them; busy seen while only receiving
		fork
			sps_link_master_inst.xfer(8'h11, 8, got);
			begin
				repeat (30) @(posedge sys_clk);
				rd(SPS_ADDR_STATUS, 8'h01);
			end
		join
		sps_link_master_inst.xfer(8'h22, 8, got);
		rd(SPS_ADDR_STATUS, 8'h20);
		rd(SPS_ADDR_RXBUF, 8'h22);
		rd(SPS_ADDR_STATUS, 8'h00);
		// seven-bit characters
		wr(SPS_ADDR_CTRL, 8'h01);
		rd(SPS_ADDR_CTRL, 8'h01);
		wr(SPS_ADDR_TXBUF, 8'hFF);
		rd(SPS_ADDR_TXBUF, 8'h7F);
		sps_link_master_inst.xfer(8'hD5, 7, got);
		chk(got, 8'h7F);
		rd(SPS_ADDR_RXBUF, 8'h55);
		// loopback: the line stays quiet and the receiver hears the transmitter
		// status writes keep the overrun bit zero and are made only while it is clear
		wr(SPS_ADDR_CTRL, 8'h00);
		wr(SPS_ADDR_STATUS, 8'h80);
		rd(SPS_ADDR_STATUS, 8'h80);
		wr(SPS_ADDR_TXBUF, 8'h96);
		rd(SPS_ADDR_IFG, 8'h08);
		sps_link_master_inst.xfer(8'h00, 8, got);
		chk(got, 8'h00);
		rd(SPS_ADDR_RXBUF, 8'h96);
		// framing flag set by hand so the buffer read has an error flag to clear
		wr(SPS_ADDR_STATUS, 8'hC0);
		rd(SPS_ADDR_STATUS, 8'hC0);
		rd(SPS_ADDR_RXBUF, 8'h96);
		rd(SPS_ADDR_STATUS, 8'h80);
		// reset in mid-run with loopback on: status, enable and flag registers must read back their reset values
		@(posedge sys_clk) srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		rd(SPS_ADDR_STATUS, 8'h00);
		rd(SPS_ADDR_IE, 8'h00);
		rd(SPS_ADDR_IFG, 8'h0A);
		irq_is(1'b0);
		wr(SPS_ADDR_STATUS, 8'h80);
		rd(SPS_ADDR_STATUS, 8'h80);
		wr(SPS_ADDR_STATUS, 8'h00);
		rd(SPS_ADDR_STATUS, 8'h00);
		report_and_stop();
	end
endmodule
`default_nettype wire
